// File: src/dbgsb_ctrl.v
// Debug controller: sync response, breakpoint, debug registers
`timescale 1ns/100ps
`default_nettype none
`include "dbgsb_regs.vh"
// Functional notes
// - Wait pin high, then 16 cycles
// - Drive pin low exactly 128 cycles
// - One-cycle high speedup, then release
// - Compare each bus address with match
// - Forced match halts at instruction boundary
// - Tagged opcode halts at queue end
// - Enable bit 5 resets 0, gates breakpoint requests
// - Bit 4 selects forced or tagged
// - Registers reached only by serial commands
// - Permit write ignored while halted
// - Four status bits are read-only
// - Clock select bit 3 resets 0
// - Permit bit 7 gates halt entry
// - Bit 6 shows halted mode active
// - Halt command needs permit bit set
// - Status read returns control register
// - Control write updates writable bits
// - Match read returns 16-bit register
module dbgsb_ctrl (
  input wire clk_sys,
  input wire rst_n,
  input wire alt_clk_tick,
  input wire debug_pin_in,
  output wire debug_pin_out,
  output wire debug_pin_oe,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  output reg [15:0] cmd_rdata,
  output reg cmd_rvalid,
  input wire [15:0] cpu_addr,
  input wire cpu_access,
  input wire cpu_opcode_fetch,
  input wire cpu_insn_boundary,
  input wire cpu_queue_end,
  input wire cpu_queue_tagged,
  input wire cpu_resume,
  input wire cpu_wait_stop,
  input wire cpu_ws_fail,
  output reg opcode_tag,
  output wire halt_request,
  output reg halted_mode_active,
  output wire debug_clock_select
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg debug_permit;
  reg breakpoint_enable;
  reg breakpoint_type_select;
  reg debug_clock_sel;
  reg wait_stop_status;
  reg wait_stop_failure;
  reg [15:0] breakpoint_match_address;
  reg pin_meta;
  reg pin_sync;
  reg forced_pending;
  wire data_valid_failure;
  wire dbg_tick;
  wire [7:0] status_byte;
  wire cmd_halt;
  wire bkpt_forced;
  wire bkpt_tagged;

  // ---------------------------------------------------------------
  // Reset image of the status/control byte
  // ---------------------------------------------------------------
  localparam [7:0] CTRL_RST = `DBGSB_CTRL_RESET;

  // Composite status/control byte
  function [7:0] pack_status;
    input p, a, e, t, c, w, f, d;
    begin
      pack_status = {p, a, e, t, c, w, f, d};
    end
  endfunction

  assign data_valid_failure = 1'b0; // No slow memory present
  assign debug_clock_select = debug_clock_sel;
  assign status_byte = pack_status(debug_permit, halted_mode_active,
    breakpoint_enable, breakpoint_type_select, debug_clock_sel,
    wait_stop_status, wait_stop_failure, data_valid_failure);

  // Debug clock tick: alternate source or every bus clock
  assign dbg_tick = debug_clock_sel ? 1'b1 : alt_clk_tick;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= debug_pin_in;
      pin_sync <= pin_meta;
    end
  end

  dbgsb_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .dbg_tick(dbg_tick),
    .pin_level(pin_sync),
    .pin_out(debug_pin_out),
    .pin_oe(debug_pin_oe),
    .sync_busy()
  );

  // ---------------------------------------------------------------
  // Breakpoint compare
  // ---------------------------------------------------------------
  // Forced type matches any access, tagged only opcode fetches; enable gates both
  assign bkpt_forced = breakpoint_enable && breakpoint_type_select &&
    cpu_access && (cpu_addr == breakpoint_match_address);
  assign bkpt_tagged = breakpoint_enable && !breakpoint_type_select &&
    cpu_opcode_fetch && (cpu_addr == breakpoint_match_address);

  // Tag follows the fetched opcode into the queue
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      opcode_tag <= 1'b0;
    end else begin
      opcode_tag <= bkpt_tagged;
    end
  end

  // Forced hit held until the next instruction boundary outside halted mode
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      forced_pending <= 1'b0;
    end else if (cpu_insn_boundary && !halted_mode_active) begin
      forced_pending <= 1'b0;
    end else if (bkpt_forced) begin
      forced_pending <= 1'b1;
    end
  end

  assign cmd_halt = cmd_valid && (cmd_code == `DBGSB_CMD_HALT);

  // Halt sources, all gated by the permit bit
  assign halt_request = debug_permit && !halted_mode_active && (
    cmd_halt ||
    ((forced_pending || bkpt_forced) && cpu_insn_boundary) ||
    (breakpoint_enable && cpu_queue_end && cpu_queue_tagged));

  // ---------------------------------------------------------------
  // Halted mode and wait/stop status
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      halted_mode_active <= CTRL_RST[`DBGSB_BIT_ACTIVE];
      wait_stop_status <= CTRL_RST[`DBGSB_BIT_WAITSTOP];
      wait_stop_failure <= CTRL_RST[`DBGSB_BIT_WSFAIL];
    end else begin
      // Halt entry wins over a resume in the same cycle
      if (halt_request) begin
        halted_mode_active <= 1'b1;
      end else if (cpu_resume) begin
        halted_mode_active <= 1'b0;
      end
      // Wait/stop entry wins over the resume clear
      if (cpu_wait_stop) begin
        wait_stop_status <= 1'b1;
      end else if (cpu_resume) begin
        wait_stop_status <= 1'b0;
      end
      // A new failure wins over the read-clear
      if (cpu_ws_fail) begin
        wait_stop_failure <= 1'b1;
      end else if (cmd_valid && cmd_code == `DBGSB_CMD_RD_STATUS) begin
        wait_stop_failure <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial command register access
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      debug_permit <= CTRL_RST[`DBGSB_BIT_PERMIT];
      breakpoint_enable <= CTRL_RST[`DBGSB_BIT_BKPT_EN];
      breakpoint_type_select <= CTRL_RST[`DBGSB_BIT_TYPE];
      debug_clock_sel <= CTRL_RST[`DBGSB_BIT_CLKSEL];
      breakpoint_match_address <= `DBGSB_MATCH_RESET;
      cmd_rdata <= 16'h0000;
      cmd_rvalid <= 1'b0;
    end else begin
      // Read strobe lasts a single cycle
      cmd_rvalid <= 1'b0;
      if (cmd_valid && cmd_code == `DBGSB_CMD_WR_CONTROL) begin
        // Status bits are never taken from the written byte
        if (!halted_mode_active) begin
          debug_permit <= cmd_wdata[`DBGSB_BIT_PERMIT];
        end
        breakpoint_enable <= cmd_wdata[`DBGSB_BIT_BKPT_EN];
        breakpoint_type_select <= cmd_wdata[`DBGSB_BIT_TYPE];
        debug_clock_sel <= cmd_wdata[`DBGSB_BIT_CLKSEL];
      end else if (cmd_valid && cmd_code == `DBGSB_CMD_WR_MATCH) begin
        breakpoint_match_address <= cmd_wdata;
      end else if (cmd_valid && cmd_code == `DBGSB_CMD_RD_STATUS) begin
        cmd_rdata <= {8'h00, status_byte};
        cmd_rvalid <= 1'b1;
      end else if (cmd_valid && cmd_code == `DBGSB_CMD_RD_MATCH) begin
        cmd_rdata <= breakpoint_match_address;
        cmd_rvalid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/dbgsb_regs.vh
// Constants for the debug sync and breakpoint controller
`ifndef DBGSB_REGS_VH
`define DBGSB_REGS_VH
// Status/control bit positions
`define DBGSB_BIT_PERMIT 7
`define DBGSB_BIT_ACTIVE 6
`define DBGSB_BIT_BKPT_EN 5
`define DBGSB_BIT_TYPE 4
`define DBGSB_BIT_CLKSEL 3
`define DBGSB_BIT_WAITSTOP 2
`define DBGSB_BIT_WSFAIL 1
`define DBGSB_BIT_DVFAIL 0
// Mask of bits the control-write command may change
`define DBGSB_CTRL_WMASK 8'hB8
// Reset values
`define DBGSB_CTRL_RESET 8'h00
`define DBGSB_MATCH_RESET 16'h0000
// Serial command codes
`define DBGSB_CMD_HALT 8'h90
`define DBGSB_CMD_RD_STATUS 8'hE4
`define DBGSB_CMD_WR_CONTROL 8'hC4
`define DBGSB_CMD_RD_MATCH 8'hE2
`define DBGSB_CMD_WR_MATCH 8'hC2
// Sync timing in debug clock cycles
`define DBGSB_SYNC_DETECT 8'd64
`define DBGSB_SYNC_DELAY 8'd16
`define DBGSB_SYNC_PULSE 8'd128
`define DBGSB_SYNC_SPEEDUP 8'd1
`endif

// File: src/dbgsb_sync.v
// Speed-probe detector and reference pulse generator
`timescale 1ns/100ps
`default_nettype none
`include "dbgsb_regs.vh"
module dbgsb_sync (
  input wire clk_sys,
  input wire rst_n,
  input wire dbg_tick,
  input wire pin_level,
  output reg pin_out,
  output reg pin_oe,
  output wire sync_busy
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_WAIT_HIGH = 5'h02;
  localparam [4:0] ST_DELAY = 5'h04;
  localparam [4:0] ST_PULSE = 5'h08;
  localparam [4:0] ST_SPEEDUP = 5'h10;
  reg [4:0] state;
  reg [7:0] count;
  assign sync_busy = (state != ST_IDLE);
  // ---------------------------------------------------------------
  // Sync sequencer, advances on debug clock ticks
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      count <= 8'h00;
      pin_out <= 1'b1;
      pin_oe <= 1'b0;
    end else if (dbg_tick) begin
      case (state)
        ST_IDLE: begin
          // Count a low longer than any bit transfer could be
          if (pin_level) begin
            count <= 8'h00;
          end else if (count == `DBGSB_SYNC_DETECT - 8'd1) begin
            state <= ST_WAIT_HIGH;
            count <= 8'h00;
          end else begin
            count <= count + 8'd1;
          end
        end
        ST_WAIT_HIGH: begin
          if (pin_level) begin
            state <= ST_DELAY;
            count <= 8'h00;
          end
        end
        ST_DELAY: begin
          if (count == `DBGSB_SYNC_DELAY - 8'd1) begin
            state <= ST_PULSE;
            count <= 8'h00;
            pin_out <= 1'b0;
            pin_oe <= 1'b1;
          end else begin
            count <= count + 8'd1;
          end
        end
        ST_PULSE: begin
          if (count == `DBGSB_SYNC_PULSE - 8'd1) begin
            state <= ST_SPEEDUP;
            count <= 8'h00;
            pin_out <= 1'b1;
          end else begin
            count <= count + 8'd1;
          end
        end
        ST_SPEEDUP: begin
          state <= ST_IDLE;
          pin_oe <= 1'b0;
          count <= 8'h00;
        end
        default: begin
          state <= ST_IDLE;
          pin_oe <= 1'b0;
          pin_out <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/dbgsb_ctrl_chk.sv
// Port assertions for the debug controller
`timescale 1ns/100ps
`default_nettype none
`include "dbgsb_regs.vh"
module dbgsb_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic debug_pin_out,
  input wire logic debug_pin_oe,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_resume,
  input wire logic opcode_tag,
  input wire logic halt_request,
  input wire logic halted_mode_active,
  input wire logic debug_clock_select
);
  logic [7:0] low_cnt;
  // Count cycles of the driven low reference level
  always @(posedge clk_sys) begin
    if (!rst_n || !debug_pin_oe || debug_pin_out) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_pulse_low: assert property (
    $rose(debug_pin_oe) |-> !debug_pin_out)
    else $error("pin drive did not start low");
  chk_pulse_len: assert property (
    debug_clock_select && debug_pin_oe && $rose(debug_pin_out)
    |-> low_cnt == 8'h80)
    else $error("reference pulse length wrong");
  chk_speedup_one: assert property (
    debug_clock_select && debug_pin_oe && debug_pin_out |=> !debug_pin_oe)
    else $error("speedup pulse longer than one cycle");
  chk_release_high: assert property (
    $fell(debug_pin_oe) |-> $past(debug_pin_out))
    else $error("pin released without speedup high");
  chk_read_cause: assert property (
    cmd_rvalid |-> $past(cmd_valid) && ($past(cmd_code) ==
    `DBGSB_CMD_RD_STATUS || $past(cmd_code) == `DBGSB_CMD_RD_MATCH))
    else $error("read data without read command");
  chk_status_read: assert property (
    cmd_valid && cmd_code == `DBGSB_CMD_RD_STATUS
    |=> cmd_rvalid && cmd_rdata[15:8] == 8'h00)
    else $error("status read answer wrong");
  chk_clksel_write: assert property (
    cmd_valid && cmd_code == `DBGSB_CMD_WR_CONTROL
    |=> debug_clock_select == |($past(cmd_wdata) & 16'h0008))
    else $error("clock select not written");
  chk_tag_fetch: assert property (
    opcode_tag |-> $past(cpu_opcode_fetch))
    else $error("tag without opcode fetch");
  chk_halt_entry: assert property (
    halt_request && !halted_mode_active |=> halted_mode_active)
    else $error("halt request not taken");
  chk_resume_exit: assert property (
    cpu_resume |=> !halted_mode_active)
    else $error("halted mode kept after resume");
endmodule
`default_nettype wire

// File: tb/dbgsb_host.sv
// Behavioural debug host pod on the single-wire pin
`timescale 1ns/100ps
`default_nettype none
module dbgsb_host (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [9:0] low_len,
  input wire logic pin,
  output logic drv_oe,
  output logic drv_out,
  output logic [11:0] gap,
  output logic [11:0] width,
  output logic done
);
  int i;
  // Issue a speed probe, then time the target reply
  initial begin
    drv_oe = 1'b0;
    drv_out = 1'b1;
    done = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        done <= 1'b0;
        drv_oe <= 1'b1;
        drv_out <= 1'b0;
        repeat (low_len) @(posedge clk_sys);
        drv_out <= 1'b1;
        @(posedge clk_sys);
        drv_oe <= 1'b0;
        #1;
        for (i = 0; pin && i < 4000; i++) begin
          @(posedge clk_sys);
          #1;
        end
        gap <= 12'(i);
        for (i = 0; !pin && i < 4000; i++) begin
          @(posedge clk_sys);
          #1;
        end
        width <= 12'(i);
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the debug sync and breakpoint controller
`timescale 1ns/100ps
`default_nettype none
`include "dbgsb_regs.vh"
module tb_top;
  logic clk_sys, rst_n, alt_clk_tick, cmd_valid, go, pin;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cpu_addr, cmd_rdata;
  logic [5:0] cpu_f;
  logic [1:0] ws_f;
  logic [9:0] low_len;
  logic [11:0] gap, width;
  logic cmd_rvalid, opcode_tag, halt_request, halted_mode_active;
  logic debug_clock_select, pin_out, pin_oe, drv_oe, drv_out, done;
  int err_count, num_checks, i;
  // Pulled-up pin seen by both parties
  assign pin = drv_oe ? drv_out : (pin_oe ? pin_out : 1'b1);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) alt_clk_tick <= ~alt_clk_tick;
  dbgsb_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .alt_clk_tick(alt_clk_tick), .debug_pin_in(pin),
    .debug_pin_out(pin_out), .debug_pin_oe(pin_oe),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cpu_addr(cpu_addr),
    .cpu_access(cpu_f[4]), .cpu_opcode_fetch(cpu_f[3]),
    .cpu_insn_boundary(cpu_f[2]), .cpu_queue_end(cpu_f[1]),
    .cpu_queue_tagged(cpu_f[0]), .cpu_resume(cpu_f[5]),
    .cpu_wait_stop(ws_f[1]), .cpu_ws_fail(ws_f[0]),
    .opcode_tag(opcode_tag),
    .halt_request(halt_request), .halted_mode_active(halted_mode_active),
    .debug_clock_select(debug_clock_select));
  dbgsb_host host_u (.clk_sys(clk_sys), .go(go), .low_len(low_len),
    .pin(pin), .drv_oe(drv_oe), .drv_out(drv_out), .gap(gap),
    .width(width), .done(done));
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmd(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e);
    cmd(c, 16'h0000);
    chk("rvalid", 16'h0001, {15'h0000, cmd_rvalid});
    chk("rdata", e, cmd_rdata);
  endtask
  task cyc(input logic [15:0] a, input logic [5:0] f);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_f <= f;
    #1;
  endtask
  task sync(input int d);
    @(posedge clk_sys);
    go <= 1'b1;
    low_len <= 10'd256;
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    for (i = 0; !done && i < 3000; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("width", 16'(128 * d), {4'h0, width});
    chk("gap", 16'h0001, {15'h0000, gap + 12'd2 >= 12'(16 * d)});
  endtask
  task end_sim;
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    {clk_sys, rst_n, alt_clk_tick, cmd_valid, go} = 5'h00;
    {cmd_code, cmd_wdata, cpu_addr, cpu_f, low_len} = 56'h0;
    ws_f = 2'h0;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`DBGSB_CMD_RD_STATUS, 16'h0000);
    rd(`DBGSB_CMD_RD_MATCH, 16'h0000);
    cmd(`DBGSB_CMD_WR_CONTROL, 16'h00FF);
    rd(`DBGSB_CMD_RD_STATUS, 16'h00B8);
    chk("clksel", 16'h0001, {15'h0000, debug_clock_select});
    cmd(`DBGSB_CMD_WR_MATCH, 16'h1234);
    rd(`DBGSB_CMD_RD_MATCH, 16'h1234);
    cyc(16'h1235, 6'h10);
    cyc(16'h0000, 6'h04);
    chk("halt", 16'h0000, {15'h0000, halt_request});
    cyc(16'h1234, 6'h10);
    cyc(16'h0000, 6'h04);
    chk("halt", 16'h0001, {15'h0000, halt_request});
    cyc(16'h0000, 6'h00);
    rd(`DBGSB_CMD_RD_STATUS, 16'h00F8);
    cmd(`DBGSB_CMD_WR_CONTROL, 16'h0038);
    rd(`DBGSB_CMD_RD_STATUS, 16'h00F8);
    cyc(16'h0000, 6'h20);
    cyc(16'h0000, 6'h00);
    chk("active", 16'h0000, {15'h0000, halted_mode_active});
    cmd(`DBGSB_CMD_WR_CONTROL, 16'h0038);
    cmd(`DBGSB_CMD_HALT, 16'h0000);
    rd(`DBGSB_CMD_RD_STATUS, 16'h0038);
    cmd(`DBGSB_CMD_WR_CONTROL, 16'h00A0);
    cmd(`DBGSB_CMD_HALT, 16'h0000);
    cyc(16'h0000, 6'h00);
    rd(`DBGSB_CMD_RD_STATUS, 16'h00E0);
    cyc(16'h0000, 6'h20);
    cyc(16'h1234, 6'h10);
    cyc(16'h0000, 6'h04);
    chk("halt", 16'h0000, {15'h0000, halt_request});
    cyc(16'h1234, 6'h18);
    cyc(16'h0000, 6'h00);
    chk("tag", 16'h0001, {15'h0000, opcode_tag});
    cyc(16'h0000, 6'h03);
    chk("halt", 16'h0001, {15'h0000, halt_request});
    cyc(16'h0000, 6'h20);
    cmd(`DBGSB_CMD_WR_CONTROL, 16'h0090);
    cyc(16'h1234, 6'h10);
    cyc(16'h0000, 6'h04);
    chk("halt", 16'h0000, {15'h0000, halt_request});
    sync(2);
    cmd(`DBGSB_CMD_WR_CONTROL, 16'h0098);
    sync(1);
    // Wait/stop events set status that control writes cannot touch
    @(posedge clk_sys);
    ws_f <= 2'h3;
    @(posedge clk_sys);
    ws_f <= 2'h0;
    cmd(`DBGSB_CMD_WR_CONTROL, 16'h0000);
    rd(`DBGSB_CMD_RD_STATUS, 16'h0006);
    rd(`DBGSB_CMD_RD_STATUS, 16'h0004);
    cyc(16'h0000, 6'h20);
    cyc(16'h0000, 6'h00);
    rd(`DBGSB_CMD_RD_STATUS, 16'h0000);
    end_sim;
  end
endmodule
bind dbgsb_ctrl dbgsb_ctrl_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .debug_pin_out(debug_pin_out), .debug_pin_oe(debug_pin_oe),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
  .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
  .cpu_opcode_fetch(cpu_opcode_fetch), .cpu_resume(cpu_resume),
  .opcode_tag(opcode_tag), .halt_request(halt_request),
  .halted_mode_active(halted_mode_active),
  .debug_clock_select(debug_clock_select));
`default_nettype wire
